// file: core/iebank_top.v
// Contract
// RULE1: an enable bit at one passes its source's request, at zero it blocks it.
// RULE2: every unimplemented enable bit reads as zero.
// RULE3: every implemented enable bit is read/write by software and resets to zero.
// RULE4: register 0 bit 2 enables output compare 1, bit 1 input capture 1, bit 0 external interrupt 0.
// RULE5: register 1 bits 15..8 enable uart2 tx, uart2 rx, ext 2, timer5, timer4, ocmp4, ocmp3, dma2.
// RULE6: register 1 bits 7..0 enable icap8, icap7, adc2, ext 1, pin change, none, i2c1 master, i2c1 slave.
// RULE7: register 2 bits 15..8 enable timer6, dma4, none, ocmp8, ocmp7, ocmp6, ocmp5, icap6.
// RULE8: register 2 bits 7..0 enable icap5, icap4, icap3, dma3, can1 event, can1 rx, spi2 event, spi2 error.
// RULE9: register 3 bit 13 enables dma5, bit 8 can2 events, bits 15-14 and 12-9 are absent.
// RULE10: register 3 bits 7..0 enable can2 rx, ext 4, ext 3, timer9, timer8, i2c2 master, i2c2 slave, timer7.
// RULE11: register 4 bits 7..4 enable can2 tx, can1 tx, dma7, dma6, bit 2 uart2 error, bit 1 uart1 error.
// RULE12: a request goes on to priority resolution only while its flag and its enable are both set.
`default_nettype none
`include "iebank_map.vh"

module iebank_top (
	// clock and reset
	input wire sys_clk,
	input wire resetn,
	input wire clk_en,
	// axi4-lite write address
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// interrupt flags from the flag bank, same clock
	input wire [15:0] irq_flag_0,
	input wire [15:0] irq_flag_1,
	input wire [15:0] irq_flag_2,
	input wire [15:0] irq_flag_3,
	input wire [15:0] irq_flag_4,
	// gated requests towards priority resolution
	output wire [15:0] irq_req_0,
	output wire [15:0] irq_req_1,
	output wire [15:0] irq_req_2,
	output wire [15:0] irq_req_3,
	output wire [15:0] irq_req_4,
	// enable state, flattened register 4..0 as [79:0]
	output wire [79:0] irq_enable_all
);

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	// address and data are latched separately so either may come first
	reg aw_held_ff;
	reg [11:0] aw_addr_ff;
	reg w_held_ff;
	reg [31:0] w_data_ff;
	reg [3:0] w_strb_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff;

	wire aw_take = s_axi_awvalid && !aw_held_ff && !bvalid_ff;
	wire w_take = s_axi_wvalid && !w_held_ff && !bvalid_ff;
	wire do_write = aw_held_ff && w_held_ff && !bvalid_ff;

	// ready stays low while frozen, so the master never sees a handshake that the logic would ignore
	// limitation: bvalid and rvalid stay up while frozen, so the master must not take an answer then
	assign s_axi_awready = clk_en && !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = clk_en && !w_held_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	wire [2:0] wr_sel;
	wire wr_hit;
	assign wr_hit = (aw_addr_ff == `IEB_OFS_EN0) || (aw_addr_ff == `IEB_OFS_EN1) ||
		(aw_addr_ff == `IEB_OFS_EN2) || (aw_addr_ff == `IEB_OFS_EN3) || (aw_addr_ff == `IEB_OFS_EN4);
	assign wr_sel = aw_addr_ff[4:2];

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= 12'h000;
			w_held_ff <= 1'b0;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `IEB_RESP_OKAY;
		end else if (clk_en) begin
			if (aw_take) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				// unmapped addresses answer with slverr and store nothing
				bresp_ff <= wr_hit ? `IEB_RESP_OKAY : `IEB_RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// enable registers
	// ----------------------------------------
	wire [79:0] en_flat;
	wire [79:0] flag_flat;
	wire [79:0] req_flat;
	// per-register implemented masks, register 0 in the low slice
	localparam [79:0] ALL_MASK = {`IEB_MASK_EN4, `IEB_MASK_EN3, `IEB_MASK_EN2, `IEB_MASK_EN1, `IEB_MASK_EN0};

	assign flag_flat = {irq_flag_4, irq_flag_3, irq_flag_2, irq_flag_1, irq_flag_0};

	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_reg
			// bit assignments of each register follow the implemented masks
			// see RULE4 see RULE5 see RULE6 see RULE7 see RULE8 see RULE9 see RULE10 see RULE11
			iebank_reg #(
				.MASK(ALL_MASK[g*16 +: 16])
			) u_reg (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.clk_en(clk_en),
				.wr_en(do_write && wr_hit && (wr_sel == g)), // see RULE3
				.wr_data(w_data_ff[15:0]),
				.wr_strb(w_strb_ff[1:0]),
				.value(en_flat[g*16 +: 16])
			);
		end
	endgenerate

	// ----------------------------------------
	// request gating
	// ----------------------------------------
	// purely combinational so a flag reaches priority logic in the same cycle
	assign req_flat = flag_flat & en_flat & ALL_MASK; // see RULE1 see RULE12 see RULE2

	assign irq_req_0 = req_flat[15:0];
	assign irq_req_1 = req_flat[31:16];
	assign irq_req_2 = req_flat[47:32];
	assign irq_req_3 = req_flat[63:48];
	assign irq_req_4 = req_flat[79:64];
	assign irq_enable_all = en_flat;

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	reg rvalid_ff;
	reg [31:0] rdata_ff;
	reg [1:0] rresp_ff;
	reg [31:0] nxt_rdata;
	reg [1:0] nxt_rresp;

	assign s_axi_arready = clk_en && !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always @* begin
		nxt_rresp = `IEB_RESP_OKAY;
		if (s_axi_araddr == `IEB_OFS_EN0) begin
			nxt_rdata = {16'h0000, en_flat[15:0]}; // see RULE2
		end else if (s_axi_araddr == `IEB_OFS_EN1) begin
			nxt_rdata = {16'h0000, en_flat[31:16]};
		end else if (s_axi_araddr == `IEB_OFS_EN2) begin
			nxt_rdata = {16'h0000, en_flat[47:32]};
		end else if (s_axi_araddr == `IEB_OFS_EN3) begin
			nxt_rdata = {16'h0000, en_flat[63:48]};
		end else if (s_axi_araddr == `IEB_OFS_EN4) begin
			nxt_rdata = {16'h0000, en_flat[79:64]};
		end else begin
			nxt_rdata = 32'h00000000;
			nxt_rresp = `IEB_RESP_SLVERR;
		end
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `IEB_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && !rvalid_ff) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= nxt_rdata; // see RULE3
				rresp_ff <= nxt_rresp;
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

endmodule // iebank_top

`default_nettype wire

// file: core/iebank_map.vh
`ifndef IEBANK_MAP_VH
`define IEBANK_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IEB_OFS_EN0 12'h000
`define IEB_OFS_EN1 12'h004
`define IEB_OFS_EN2 12'h008
`define IEB_OFS_EN3 12'h00C
`define IEB_OFS_EN4 12'h010

// ----------------------------------------
// implemented-bit masks (zero = unimplemented, reads zero)
// ----------------------------------------
`define IEB_MASK_EN0 16'h7FFF
`define IEB_MASK_EN1 16'hFFFB
`define IEB_MASK_EN2 16'hDFFF
`define IEB_MASK_EN3 16'h21FF
`define IEB_MASK_EN4 16'h00F6

// ----------------------------------------
// reset values
// ----------------------------------------
`define IEB_RST_EN 16'h0000

// ----------------------------------------
// named field positions
// ----------------------------------------
`define IEB_BIT_OCMP1 2
`define IEB_BIT_ICAP1 1
`define IEB_BIT_EXT0 0

// ----------------------------------------
// bus answers
// ----------------------------------------
`define IEB_RESP_OKAY 2'h0
`define IEB_RESP_SLVERR 2'h2

`endif

// file: core/iebank_reg.v
`default_nettype none
`include "iebank_map.vh"

// one 16-bit enable register with byte strobes and a fixed implemented mask
module iebank_reg #(
	parameter [15:0] MASK = 16'hFFFF
) (
	// clock and reset
	input wire sys_clk,
	input wire resetn,
	input wire clk_en,
	// write port
	input wire wr_en,
	input wire [15:0] wr_data,
	input wire [1:0] wr_strb,
	// state
	output wire [15:0] value
);

	reg [15:0] en_ff;
	reg [15:0] nxt_en;
	integer i;

	always @* begin
		nxt_en = en_ff;
		if (wr_en) begin
			for (i = 0; i < 16; i = i + 1) begin
				if (wr_strb[i / 8]) begin
					nxt_en[i] = wr_data[i];
				end
			end
		end
		nxt_en = nxt_en & MASK; // see RULE2
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			en_ff <= `IEB_RST_EN; // see RULE3
		end else if (clk_en) begin
			en_ff <= nxt_en; // see RULE3
		end
	end

	assign value = en_ff;

endmodule // iebank_reg

`default_nettype wire

// file: verification/iebank_assertions.sv
`default_nettype none
`include "iebank_map.vh"
module iebank_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// register bus
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// gating
	input wire logic [15:0] irq_flag_0,
	input wire logic [15:0] irq_flag_3,
	input wire logic [15:0] irq_req_0,
	input wire logic [15:0] irq_req_3,
	input wire logic [79:0] irq_enable_all
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [79:0] MSK = {`IEB_MASK_EN4, `IEB_MASK_EN3, `IEB_MASK_EN2, `IEB_MASK_EN1, `IEB_MASK_EN0};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	gate_req0_a: assert property (irq_req_0 == (irq_flag_0 & irq_enable_all[15:0]))
		else $error("request 0 not flag and enable");
	gate_req3_a: assert property (irq_req_3 == (irq_flag_3 & irq_enable_all[63:48]))
		else $error("request 3 not flag and enable");
	unimpl_zero_a: assert property ((irq_enable_all & ~MSK) == 80'h0)
		else $error("unimplemented enable set");
	reset_clear_a: assert property ($rose(resetn) |-> irq_enable_all == 80'h0)
		else $error("enables not clear after reset");
	rd_latency_a: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (irq_req_0 != 16'h0000);
endmodule // iebank_chk
bind iebank_top iebank_chk u_chk (.*);
`default_nettype wire

// file: verification/iebank_src.sv
`default_nettype none
// peripheral side: flag levels appear one clock after the test asks for them
module iebank_src (
	// clock
	input wire logic sys_clk,
	// flags
	input wire logic [79:0] flag_set,
	output logic [79:0] flags
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge sys_clk) begin
		flags <= flag_set;
	end
endmodule // iebank_src
`default_nettype wire

// file: verification/iebank_top_tb.sv
`default_nettype none
`include "iebank_map.vh"
module iebank_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [79:0] MSK = {`IEB_MASK_EN4, `IEB_MASK_EN3, `IEB_MASK_EN2, `IEB_MASK_EN1, `IEB_MASK_EN0};
	logic sys_clk, resetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [15:0] irq_flag_0, irq_flag_1, irq_flag_2, irq_flag_3, irq_flag_4;
	logic [15:0] irq_req_0, irq_req_1, irq_req_2, irq_req_3, irq_req_4;
	logic [79:0] irq_enable_all, flag_set, flags, req, d;
	int errors, compares, i;
	int bits [3] = '{`IEB_BIT_OCMP1, `IEB_BIT_ICAP1, `IEB_BIT_EXT0};
	assign {irq_flag_4, irq_flag_3, irq_flag_2, irq_flag_1, irq_flag_0} = flags;
	assign req = {irq_req_4, irq_req_3, irq_req_2, irq_req_1, irq_req_0};
	iebank_top u_dut (.*);
	iebank_src u_src (.sys_clk(sys_clk), .flag_set(flag_set), .flags(flags));
	always #5 sys_clk = ~sys_clk;
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic complete_run;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 99) begin
			errors++;
			complete_run();
		end
	endtask
	// ready goes up with the request and stays up until the answer is sampled
	task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [3:0] s);
		int n;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, v};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tmo(n);
	endtask
	task automatic rd(input logic [11:0] a);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = {48'h0, s_axi_rdata};
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tmo(n);
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{sys_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = 66'h0;
		clk_en = 1'b1;
		flag_set = {80{1'b1}};
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		for (i = 0; i < 5; i++) begin
			rd(12'(i * 4));
			chk("reset value", 80'h0, d);
		end
		chk("gated at reset", 80'h0, req);
		$display("test reset done");
		for (i = 0; i < 5; i++) begin
			wr(12'(i * 4), 16'hFFFF, 4'hF);
			chk("write resp", `IEB_RESP_OKAY, r);
			rd(12'(i * 4));
			chk("readback", MSK[i * 16 +: 16], d);
		end
		chk("enables", MSK, irq_enable_all);
		chk("gated on", MSK, req);
		flag_set <= 80'h0;
		repeat (2) @(posedge sys_clk);
		chk("gated no flag", 80'h0, req);
		flag_set <= {80{1'b1}};
		$display("test all on done");
		wr(`IEB_OFS_EN1, 16'h0000, 4'h1);
		rd(`IEB_OFS_EN1);
		chk("byte lane", 80'hFF00, d);
		chk("lane gating", 80'hFF00, irq_req_1);
		$display("test byte lane done");
		wr(12'h014, 16'h0000, 4'hF);
		chk("unmapped bresp", `IEB_RESP_SLVERR, r);
		rd(12'h014);
		chk("unmapped rresp", `IEB_RESP_SLVERR, r);
		chk("unmapped data", 80'h0, d);
		chk("enables kept", MSK & ~80'hFF_0000, irq_enable_all);
		$display("test unmapped done");
		for (i = 0; i < 3; i++) begin
			wr(`IEB_OFS_EN0, 16'h0001 << bits[i], 4'h3);
			chk("named bit", 80'h1 << bits[i], irq_req_0);
		end
		$display("test named bits done");
		// a read offered while frozen must wait and then complete once running again
		clk_en <= 1'b0;
		fork
			rd(`IEB_OFS_EN0);
			begin
				repeat (4) @(posedge sys_clk);
				chk("frozen rvalid", 80'h0, s_axi_rvalid);
				chk("frozen enables", 80'h1, irq_enable_all[15:0]);
				clk_en <= 1'b1;
			end
		join
		chk("read after freeze", 80'h1, d);
		$display("test clock enable done");
		resetn <= 1'b0;
		@(posedge sys_clk);
		chk("enables in reset", 80'h0, irq_enable_all);
		chk("gated in reset", 80'h0, req);
		resetn <= 1'b1;
		rd(`IEB_OFS_EN0);
		chk("reg 0 after reset", 80'h0, d);
		$display("test mid-run reset done");
		complete_run();
	end
endmodule // iebank_top_tb
`default_nettype wire
